/* src/ccp_pkg.sv */
package ccp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CCP_NCH = 2;
  localparam int CCP_CNT_W = 16;
  localparam int CCP_CTL_W = 4;
  // channel indices; CCP_CH4 is the channel that may capture on the neighbour event
  localparam int CCP_CH4 = 0;
  localparam int CCP_CH5 = 1;

  // ----------------------------------------------------------------
  // control field layout
  // ----------------------------------------------------------------
  localparam int CCP_BIT_CAP = 3;
  localparam int CCP_BIT_INIT = 2;
  localparam int CCP_BIT_BOTH = 1;
  localparam int CCP_BIT_FALL = 0;

  // ----------------------------------------------------------------
  // compare actions in bits 1:0
  // ----------------------------------------------------------------
  localparam logic [1:0] CCP_ACT_OFF = 2'h0;
  localparam logic [1:0] CCP_ACT_LOW = 2'h1;
  localparam logic [1:0] CCP_ACT_HIGH = 2'h2;
  localparam logic [1:0] CCP_ACT_TOG = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CCP_CTL_W-1:0] CCP_CTL_RST = 4'h0;
  localparam logic [CCP_CNT_W-1:0] CCP_REG_RST = 16'hFFFF;
  localparam logic CCP_PIN_RST = 1'b0;

endpackage

/* src/ccp_edge_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ccp_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

/* src/ccp_pin_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_edge
  import ccp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  ccp_edge_if.src edge_o
);

  // ----------------------------------------------------------------
  // synchroniser and edge detector
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } ccp_edge_st_t;

  ccp_edge_st_t st_ff;
  ccp_edge_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pin_i;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign edge_o.level = st_ff.sync;
  assign edge_o.rise = st_ff.sync & ~st_ff.prev;
  assign edge_o.fall = ~st_ff.sync & st_ff.prev;

endmodule
`default_nettype wire

/* src/ccp_pin_ctrl.sv */
// How it works
// - Field 0x01 or 0x05 is output compare that drives the pin low at each match, from the level in bit 2.
// - Field 0x02 or 0x06 is output compare that drives the pin high at each match, from the level in bit 2.
// - Field 0x03 or 0x07 toggles the pin at each match from the bit 2 level, and bits 1:0 of 00 disable the pin.
// - Field 0x08 makes the A register capture the counter on a rising pin edge.
// - Field 0x09 makes the A register capture the counter on a falling pin edge.
// - Capture with bit 1 set takes both pin edges and ignores bit 0, except on channel 4 with bit 2 set.
// - Channel 4 with bits 3 and 2 set captures on the channel 3 A-register event and ignores bits 1:0.
// - Channel 4 with bit 3 set and bit 2 clear captures from its own pin on the edge chosen by bits 1:0.
// - Channel 5 in capture mode ignores bit 2 and always captures from its own pin.
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_ctrl
  import ccp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [CCP_CTL_W-1:0] ch4_io_control_i,
  input wire logic [CCP_CTL_W-1:0] ch5_io_control_i,
  input wire logic [CCP_CNT_W-1:0] ch4_count_i,
  input wire logic [CCP_CNT_W-1:0] ch5_count_i,
  input wire logic ch4_reg_a_wr_i,
  input wire logic ch5_reg_a_wr_i,
  input wire logic [CCP_CNT_W-1:0] reg_a_wdata_i,
  input wire logic ch3_a_event_i,
  input wire logic ch4_pin_a_i,
  input wire logic ch5_pin_a_i,
  output logic ch4_pin_a_o,
  output logic ch4_pin_a_oe_o,
  output logic ch5_pin_a_o,
  output logic ch5_pin_a_oe_o,
  output logic [CCP_CNT_W-1:0] ch4_general_reg_a_o,
  output logic [CCP_CNT_W-1:0] ch5_general_reg_a_o,
  output logic ch4_a_event_o,
  output logic ch5_a_event_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_ff;
  logic rst_sync_n;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_ff[1];

  // ----------------------------------------------------------------
  // per-channel inputs and pin edges
  // ----------------------------------------------------------------
  logic [CCP_NCH-1:0][CCP_CTL_W-1:0] ctl;
  logic [CCP_NCH-1:0][CCP_CNT_W-1:0] cnt;
  logic [CCP_NCH-1:0] wr;
  logic [CCP_NCH-1:0] pin_in;
  logic [CCP_NCH-1:0] rise;
  logic [CCP_NCH-1:0] fall;

  assign ctl = {ch5_io_control_i, ch4_io_control_i};
  assign cnt = {ch5_count_i, ch4_count_i};
  assign wr = {ch5_reg_a_wr_i, ch4_reg_a_wr_i};
  assign pin_in = {ch5_pin_a_i, ch4_pin_a_i};

  ccp_edge_if eif[CCP_NCH] ();

  for (genvar g = 0; g < CCP_NCH; g++) begin : g_pin
    ccp_pin_edge u_edge (
      .clock_i(clock_i),
      .rst_n_i(rst_sync_n),
      .pin_i(pin_in[g]),
      .edge_o(eif[g])
    );
    assign rise[g] = eif[g].rise;
    assign fall[g] = eif[g].fall;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CCP_NCH-1:0][CCP_CTL_W-1:0] ctl_q;
    logic [CCP_NCH-1:0] pin;
    logic [CCP_NCH-1:0] oe;
    logic [CCP_NCH-1:0][CCP_CNT_W-1:0] reg_a;
    logic [CCP_NCH-1:0] evt;
  } ccp_state_t;

  ccp_state_t st_ff;
  ccp_state_t nxt_st;

  // ----------------------------------------------------------------
  // match, field change and capture trigger
  // ----------------------------------------------------------------
  logic [CCP_NCH-1:0] match;
  logic [CCP_NCH-1:0] chg;
  logic [CCP_NCH-1:0] trig;

  always_comb begin
    for (int c = 0; c < CCP_NCH; c++) begin
      match[c] = !ctl[c][CCP_BIT_CAP] && (cnt[c] == st_ff.reg_a[c]);
      chg[c] = ctl[c] != st_ff.ctl_q[c];
      trig[c] = 1'b0;
      if (ctl[c][CCP_BIT_CAP]) begin
        if (c == CCP_CH4 && ctl[c][CCP_BIT_INIT]) begin
          trig[c] = ch3_a_event_i;
        end else if (ctl[c][CCP_BIT_BOTH]) begin
          trig[c] = rise[c] | fall[c];
        end else if (ctl[c][CCP_BIT_FALL]) begin
          trig[c] = fall[c];
        end else begin
          trig[c] = rise[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    for (int c = 0; c < CCP_NCH; c++) begin
      nxt_st.ctl_q[c] = ctl[c];
      nxt_st.evt[c] = 1'b0;
      if (wr[c]) begin
        nxt_st.reg_a[c] = reg_a_wdata_i;
      end
      if (!ctl[c][CCP_BIT_CAP]) begin
        nxt_st.oe[c] = ctl[c][1:0] != CCP_ACT_OFF;
        nxt_st.evt[c] = match[c];
        if (chg[c]) begin
          nxt_st.pin[c] = ctl[c][CCP_BIT_INIT];
        end else if (match[c]) begin
          case (ctl[c][1:0])
            CCP_ACT_LOW: nxt_st.pin[c] = 1'b0;
            CCP_ACT_HIGH: nxt_st.pin[c] = 1'b1;
            CCP_ACT_TOG: nxt_st.pin[c] = ~st_ff.pin[c];
            default: nxt_st.pin[c] = st_ff.pin[c];
          endcase
        end
      end else begin
        // capture takes the counter, winning over a write
        nxt_st.oe[c] = 1'b0;
        if (trig[c]) begin
          nxt_st.reg_a[c] = cnt[c];
          nxt_st.evt[c] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff.ctl_q <= {CCP_NCH{CCP_CTL_RST}};
      st_ff.pin <= {CCP_NCH{CCP_PIN_RST}};
      st_ff.oe <= '0;
      st_ff.reg_a <= {CCP_NCH{CCP_REG_RST}};
      st_ff.evt <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ch4_pin_a_o = st_ff.pin[CCP_CH4];
  assign ch4_pin_a_oe_o = st_ff.oe[CCP_CH4];
  assign ch5_pin_a_o = st_ff.pin[CCP_CH5];
  assign ch5_pin_a_oe_o = st_ff.oe[CCP_CH5];
  assign ch4_general_reg_a_o = st_ff.reg_a[CCP_CH4];
  assign ch5_general_reg_a_o = st_ff.reg_a[CCP_CH5];
  assign ch4_a_event_o = st_ff.evt[CCP_CH4];
  assign ch5_a_event_o = st_ff.evt[CCP_CH5];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_sync_n);

  cmp_low_a: assert property (
    (ch4_io_control_i[3] == 1'b0 && ch4_io_control_i[1:0] == 2'h1 && match[0] && !chg[0])
    |=> (!ch4_pin_a_o && ch4_pin_a_oe_o && ch4_a_event_o))
    else $error("ch4 pin not low after match");

  cmp_high_a: assert property (
    (ch5_io_control_i[3] == 1'b0 && ch5_io_control_i[1:0] == 2'h2 && match[1] && !chg[1])
    |=> (ch5_pin_a_o && ch5_pin_a_oe_o))
    else $error("ch5 pin not high after match");

  cmp_toggle_a: assert property (
    (ch4_io_control_i[3] == 1'b0 && ch4_io_control_i[1:0] == 2'h3 && match[0] && !chg[0])
    |=> (ch4_pin_a_o == !$past(ch4_pin_a_o)))
    else $error("ch4 pin did not toggle");

  out_disable_a: assert property (
    (ch4_io_control_i[3] == 1'b0 && ch4_io_control_i[1:0] == 2'h0)[*2] |-> !ch4_pin_a_oe_o)
    else $error("ch4 pin driven while disabled");

  cap_rise_a: assert property (
    (ch4_io_control_i == 4'h8 && rise[0]) |=> (ch4_general_reg_a_o == $past(ch4_count_i)
      && ch4_a_event_o))
    else $error("ch4 rising capture missed");

  cap_fall_a: assert property (
    (ch5_io_control_i[3] && ch5_io_control_i[1:0] == 2'h1 && fall[1])
    |=> (ch5_general_reg_a_o == $past(ch5_count_i)))
    else $error("ch5 falling capture missed");

  cap_both_a: assert property (
    (ch5_io_control_i[3] && ch5_io_control_i[1] && (rise[1] || fall[1]))
    |=> (ch5_general_reg_a_o == $past(ch5_count_i)))
    else $error("ch5 both-edge capture missed");

  cap_neighbour_a: assert property (
    (ch4_io_control_i[3:2] == 2'h3 && ch3_a_event_i) |=> (ch4_a_event_o
      && ch4_general_reg_a_o == $past(ch4_count_i)))
    else $error("ch4 neighbour capture missed");

  own_pin_only_a: assert property (
    (ch4_io_control_i == 4'h8 && !rise[0] && !ch4_reg_a_wr_i) |=> $stable(ch4_general_reg_a_o))
    else $error("ch4 captured without rising edge");

  ch5_no_nbr_a: assert property (
    (ch5_io_control_i == 4'hC && !rise[1] && !ch5_reg_a_wr_i) |=> $stable(ch5_general_reg_a_o))
    else $error("ch5 captured on a foreign source");

  init_level_a: assert property (
    (chg[0] && !ch4_io_control_i[3] && ch4_io_control_i[1:0] != 2'h0)
    |=> (ch4_pin_a_o == $past(ch4_io_control_i[2]) && ch4_pin_a_oe_o))
    else $error("ch4 initial level not applied");

endmodule
`default_nettype wire

/* sim/ccp_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_far_model (
  input wire logic clock_i,
  input wire logic [1:0] oe_i,
  input wire logic [1:0] out_i,
  output logic [1:0] pin_o,
  output logic ch3_event_o
);
  // ----------------------------------------------------------------
  // outside pin sources and channel 3 event
  // ----------------------------------------------------------------
  logic [1:0] ext_lvl;

  // wire level: the channel wins while it drives, else the outside source
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_lvl);

  initial begin
    ext_lvl = 2'h0;
    ch3_event_o = 1'b0;
  end

  task automatic drive(input int ch, input logic v);
    ext_lvl[ch] = v;
  endtask

  // one-cycle pulse, launched just after an edge
  task automatic ch3_pulse();
    ch3_event_o = 1'b1;
    @(posedge clock_i);
    #1 ch3_event_o = 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/tb_capture_compare_pin_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_capture_compare_pin_control;
  import ccp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [CCP_CTL_W-1:0] ctl [2];
  logic [CCP_CNT_W-1:0] cnt [2];
  logic [CCP_CNT_W-1:0] rega [2];
  logic [CCP_CNT_W-1:0] wdata;
  logic [1:0] wr, oe, po, pin, ev;
  logic ch3_ev;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clock_i = ~clock_i;

  ccp_pin_ctrl uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .ch4_io_control_i(ctl[0]), .ch5_io_control_i(ctl[1]),
    .ch4_count_i(cnt[0]), .ch5_count_i(cnt[1]),
    .ch4_reg_a_wr_i(wr[0]), .ch5_reg_a_wr_i(wr[1]), .reg_a_wdata_i(wdata),
    .ch3_a_event_i(ch3_ev), .ch4_pin_a_i(pin[0]), .ch5_pin_a_i(pin[1]),
    .ch4_pin_a_o(po[0]), .ch4_pin_a_oe_o(oe[0]),
    .ch5_pin_a_o(po[1]), .ch5_pin_a_oe_o(oe[1]),
    .ch4_general_reg_a_o(rega[0]), .ch5_general_reg_a_o(rega[1]),
    .ch4_a_event_o(ev[0]), .ch5_a_event_o(ev[1])
  );

  ccp_far_model far (
    .clock_i(clock_i), .oe_i(oe), .out_i(po), .pin_o(pin), .ch3_event_o(ch3_ev)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic set_ctl(input int ch, input logic [3:0] v);
    ctl[ch] = v;
    step(1);
  endtask

  task automatic write_a(input int ch, input logic [15:0] v);
    wr[ch] = 1'b1;
    wdata = v;
    step(1);
    wr[ch] = 1'b0;
  endtask

  task automatic match(input int ch, input logic exp_pin);
    cnt[ch] = rega[ch];
    step(1);
    cnt[ch] = 16'h0000;
    chk("match event", 16'h0001, {15'h0000, ev[ch]});
    chk("match pin", {15'h0000, exp_pin}, {15'h0000, po[ch]});
    // event stands one cycle, pin holds
    step(1);
    chk("event end", 16'h0000, {15'h0000, ev[ch]});
    chk("pin hold", {15'h0000, exp_pin}, {15'h0000, po[ch]});
  endtask

  task automatic cap(input int ch, input logic v, input logic exp);
    logic seen;
    seen = 1'b0;
    write_a(ch, 16'h0000);
    far.drive(ch, v);
    repeat (6) begin
      step(1);
      seen |= ev[ch];
    end
    chk("capture", {15'h0000, exp}, {15'h0000, seen});
    chk("capture reg", exp ? cnt[ch] : 16'h0000, rega[ch]);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] code;
    logic nbr;
    logic exp_lvl;
    ctl[0] = 4'h0;
    ctl[1] = 4'h0;
    cnt[0] = 16'h0000;
    cnt[1] = 16'h0000;
    wr = 2'h0;
    wdata = 16'h0000;
    repeat (4) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    step(3);
    for (int ch = 0; ch < 2; ch++) begin
      chk("reset oe", 16'h0000, {15'h0000, oe[ch]});
      chk("reset pin", {15'h0000, CCP_PIN_RST}, {15'h0000, po[ch]});
      chk("reset event", 16'h0000, {15'h0000, ev[ch]});
      chk("reset reg", CCP_REG_RST, rega[ch]);
    end
    $display("test reset done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        code = c[3:0];
        set_ctl(ch, code);
        chk("oe", {15'h0000, code[1:0] != 2'h0}, {15'h0000, oe[ch]});
        if (code[1:0] != CCP_ACT_OFF) begin
          chk("initial", {15'h0000, code[2]}, {15'h0000, po[ch]});
          write_a(ch, 16'h0100 + c[15:0]);
          chk("write reg", 16'h0100 + c[15:0], rega[ch]);
          exp_lvl = (code[1:0] == CCP_ACT_TOG) ? ~code[2] : (code[1:0] == CCP_ACT_HIGH);
          match(ch, exp_lvl);
          match(ch, (code[1:0] == CCP_ACT_TOG) ? code[2] : exp_lvl);
        end
      end
    end
    $display("test compare done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 8; c < 16; c++) begin
        code = c[3:0];
        nbr = (ch == CCP_CH4) && code[2];
        set_ctl(ch, code);
        far.drive(ch, 1'b0);
        cnt[ch] = 16'h5A00 + c[15:0];
        step(6);
        chk("capture oe", 16'h0000, {15'h0000, oe[ch]});
        cap(ch, 1'b1, !nbr && (code[1] || !code[0]));
        cap(ch, 1'b0, !nbr && (code[1] || code[0]));
        write_a(ch, 16'h0000);
        far.ch3_pulse();
        chk("nbr event", {15'h0000, nbr}, {15'h0000, ev[ch]});
        chk("nbr reg", nbr ? cnt[ch] : 16'h0000, rega[ch]);
      end
    end
    $display("test capture done");
    // reset in mid-run, with a compare code waiting at release
    rst_n_i = 1'b0;
    ctl[0] = 4'h5;
    step(2);
    for (int ch = 0; ch < 2; ch++) begin
      chk("reset oe", 16'h0000, {15'h0000, oe[ch]});
      chk("reset pin", {15'h0000, CCP_PIN_RST}, {15'h0000, po[ch]});
      chk("reset event", 16'h0000, {15'h0000, ev[ch]});
      chk("reset reg", CCP_REG_RST, rega[ch]);
    end
    rst_n_i = 1'b1;
    step(3);
    chk("release init", 16'h0001, {15'h0000, po[0]});
    chk("release oe", 16'h0001, {15'h0000, oe[0]});
    $display("test reset again done");
    results();
  end
endmodule
`default_nettype wire
